//--- rtl/usbe_device.sv
// How it works
// - Shared toggle picks DATA0 or DATA1
// - Select bit: shared buffer to endpoint 1/2
// - Endpoint 2 IN NAKed when select says 0
// - Shared IN NAKed if disabled or done
// - Software arms enable, clears when finished
// - Wakeup bit drives K; software times it
// - Wakeup never sets resume detect flag
// - Low nibble holds shared byte count
// - Auto status answers control read OUT
// - Endpoint enables at bits 3 and 2
// - Forced stalls at bits 1 and 0
// - Receive toggle compared with data PID
// - SETUP token to endpoint 0 sets setup status bit
// - IN and OUT tokens to endpoint 0 set status bits
// - Receive byte count in low nibble
// - Prescaler divides halved clock to USB rate
// - Prescaler values 0 to 255 supported
// - Done flag set on ACK, software clears
// - Forced stall answers IN and OUT
// - Activity while suspended sets resume flag
`timescale 1ns/1ps
module usbe_device #(
  parameter int BUF_DEPTH = 8,
  parameter int SUSP_TICKS = usbe_pkg::SUSP_TICKS
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  usbe_link_if.dev lnk
);
  localparam int AW = $clog2(BUF_DEPTH);

  generate
    if (BUF_DEPTH < 2 || BUF_DEPTH > 16 || (1 << AW) != BUF_DEPTH ||
        SUSP_TICKS < 2 || SUSP_TICKS > 65535) begin : g_bad
      $error("usbe_device: unsupported parameters");
    end
  endgenerate

  typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX, ST_WACK} usbe_dst_t;

  typedef struct packed {
    usbe_dst_t st;
    logic [7:0] presc;
    logic [7:0] tx0last;
    logic [7:0] tx1last;
    logic [7:0] evst;
    logic [7:0] even;
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] rxst;
    logic [7:0] faddr;
    logic [7:0] rdata;
    logic [BUF_DEPTH-1:0][7:0] buf0;
    logic [BUF_DEPTH-1:0][7:0] buf1;
    logic [BUF_DEPTH-1:0][7:0] rbuf;
    logic [AW-1:0] wp0;
    logic [AW-1:0] wp1;
    logic [AW-1:0] rp;
    logic [3:0] idx;
    logic [3:0] cnt;
    logic [3:0] tok;
    logic [3:0] dpid;
    logic shared;
    logic rtog;
    logic [15:0] idle;
    usbe_pkg::usbe_beat_t db;
  } usbe_dev_t;

  usbe_dev_t s, n;
  logic tick;

  usbe_tick_div #(.W(8)) u_div (
    .core_clk(core_clk),
    .nrst(nrst),
    .presc(s.presc),
    .tick(tick)
  );

  always_comb begin
    n = s;
    n.db = '0;
    // -------------------------------------------------------------
    // Register reads
    // -------------------------------------------------------------
    if (sfr_rd) begin
      case (sfr_addr)
        usbe_pkg::ADR_PRESC: n.rdata = s.presc;
        usbe_pkg::ADR_TX1DATA: n.rdata = s.tx1last;
        usbe_pkg::ADR_TX0DATA: n.rdata = s.tx0last;
        usbe_pkg::ADR_EVSTAT: n.rdata = s.evst;
        usbe_pkg::ADR_EVEN: n.rdata = s.even;
        usbe_pkg::ADR_TX0CTL: n.rdata = s.ctl0;
        usbe_pkg::ADR_TX1CTL: n.rdata = s.ctl1;
        usbe_pkg::ADR_EPCTL: n.rdata = s.ctl2 & usbe_pkg::EPCTL_MASK;
        usbe_pkg::ADR_RXSTAT: n.rdata = s.rxst;
        usbe_pkg::ADR_FADDR: n.rdata = s.faddr;
        usbe_pkg::ADR_RXDATA: begin
          n.rdata = s.rbuf[s.rp];
          n.rp = s.rp + 1'b1;
        end
        default: n.rdata = usbe_pkg::RST_VAL;
      endcase
    end
    // -------------------------------------------------------------
    // Register writes
    // -------------------------------------------------------------
    if (sfr_wr) begin
      case (sfr_addr)
        usbe_pkg::ADR_PRESC: n.presc = sfr_wdata;
        usbe_pkg::ADR_TX1DATA: begin
          n.tx1last = sfr_wdata;
          n.buf1[s.wp1] = sfr_wdata;
          n.wp1 = s.wp1 + 1'b1;
        end
        usbe_pkg::ADR_TX0DATA: begin
          n.tx0last = sfr_wdata;
          n.buf0[s.wp0] = sfr_wdata;
          n.wp0 = s.wp0 + 1'b1;
        end
        usbe_pkg::ADR_EVSTAT: begin
          n.evst = sfr_wdata;
          n.evst[usbe_pkg::B_SUSP] = s.evst[usbe_pkg::B_SUSP];
        end
        usbe_pkg::ADR_EVEN: n.even = sfr_wdata;
        usbe_pkg::ADR_TX0CTL: begin
          n.ctl0 = sfr_wdata;
          n.wp0 = '0;
        end
        usbe_pkg::ADR_TX1CTL: begin
          n.ctl1 = sfr_wdata;
          n.wp1 = '0;
        end
        usbe_pkg::ADR_EPCTL: n.ctl2 = sfr_wdata & usbe_pkg::EPCTL_MASK;
        usbe_pkg::ADR_RXSTAT:
          n.rxst[usbe_pkg::B_RXTOG] = sfr_wdata[usbe_pkg::B_RXTOG];
        usbe_pkg::ADR_FADDR: n.faddr = sfr_wdata;
        default: ;
      endcase
    end
    // -------------------------------------------------------------
    // Suspend and resume, after writes so hardware sets win
    // -------------------------------------------------------------
    if (tick) begin
      if (lnk.h.v) begin
        n.idle = '0;
        if (s.evst[usbe_pkg::B_SUSP]) begin
          n.evst[usbe_pkg::B_RESUME] = 1'b1;
          n.evst[usbe_pkg::B_SUSP] = 1'b0;
        end
      end else if (s.idle == 16'(SUSP_TICKS - 1)) begin
        n.evst[usbe_pkg::B_SUSP] = 1'b1;
      end else begin
        n.idle = s.idle + 16'h0001;
      end
    end
    // -------------------------------------------------------------
    // Transaction engine, one step per USB tick
    // -------------------------------------------------------------
    if (tick) begin
      case (s.st)
        ST_IDLE: begin
          if (lnk.h.v) begin
            n.tok = lnk.h.pid;
            n.dpid = lnk.h.ep;
            n.idx = '0;
            if (lnk.h.ep == usbe_pkg::EP_ZERO) begin
              n.rxst[usbe_pkg::B_SETUP] = lnk.h.pid == usbe_pkg::PID_SETUP;
              n.rxst[usbe_pkg::B_IN] = lnk.h.pid == usbe_pkg::PID_IN;
              n.rxst[usbe_pkg::B_OUT] = lnk.h.pid == usbe_pkg::PID_OUT;
            end
            if (lnk.h.pid == usbe_pkg::PID_SETUP) begin
              n.st = ST_RX;
              if (lnk.h.ep == usbe_pkg::EP_ZERO) begin
                n.ctl0[usbe_pkg::B_EP0_FORCED_STALL] = 1'b0;
              end
            end else if (lnk.h.pid == usbe_pkg::PID_OUT) begin
              n.st = ST_RX;
            end else if (lnk.h.pid == usbe_pkg::PID_IN) begin
              if (lnk.h.ep == usbe_pkg::EP_ZERO) begin
                if (s.ctl0[usbe_pkg::B_EP0_FORCED_STALL]) begin
                  n.db = usbe_pkg::hsk(usbe_pkg::PID_STALL);
                end else if (!s.ctl0[usbe_pkg::B_TXEN] ||
                             s.evst[usbe_pkg::B_TX0DONE]) begin
                  n.db = usbe_pkg::hsk(usbe_pkg::PID_NAK);
                end else begin
                  n.st = ST_TX;
                  n.shared = 1'b0;
                  n.cnt = usbe_pkg::cnt_of(s.ctl0);
                  n.dpid = s.ctl0[usbe_pkg::B_TOGGLE] ?
                           usbe_pkg::PID_DATA1 : usbe_pkg::PID_DATA0;
                end
              end else if ((lnk.h.ep == usbe_pkg::EP_ONE &&
                            s.ctl2[usbe_pkg::B_EP1EN]) ||
                           (lnk.h.ep == usbe_pkg::EP_TWO &&
                            s.ctl2[usbe_pkg::B_EP2EN])) begin
                if (lnk.h.ep == usbe_pkg::EP_ONE ?
                    s.ctl2[usbe_pkg::B_EP1STALL] :
                    s.ctl2[usbe_pkg::B_EP2STALL]) begin
                  n.db = usbe_pkg::hsk(usbe_pkg::PID_STALL);
                end else if (!s.ctl1[usbe_pkg::B_TXEN] ||
                             s.evst[usbe_pkg::B_TX1DONE]) begin
                  n.db = usbe_pkg::hsk(usbe_pkg::PID_NAK);
                end else if (s.ctl1[usbe_pkg::B_SELECT] !=
                             (lnk.h.ep == usbe_pkg::EP_TWO)) begin
                  n.db = usbe_pkg::hsk(usbe_pkg::PID_NAK);
                end else begin
                  n.st = ST_TX;
                  n.shared = 1'b1;
                  n.cnt = usbe_pkg::cnt_of(s.ctl1);
                  n.dpid = s.ctl1[usbe_pkg::B_TOGGLE] ?
                           usbe_pkg::PID_DATA1 : usbe_pkg::PID_DATA0;
                end
              end
            end
          end
        end
        ST_RX: begin
          if (lnk.h.v) begin
            n.rtog = lnk.h.pid == usbe_pkg::PID_DATA1;
            if (!lnk.h.empty) begin
              n.rbuf[s.idx[AW-1:0]] = lnk.h.b;
              n.idx = s.idx + 4'h1;
            end
            if (lnk.h.last) begin
              n.st = ST_IDLE;
              if (s.dpid != usbe_pkg::EP_ZERO) begin
                if ((s.dpid == usbe_pkg::EP_ONE && s.ctl2[usbe_pkg::B_EP1EN]) ||
                    (s.dpid == usbe_pkg::EP_TWO && s.ctl2[usbe_pkg::B_EP2EN])) begin
                  n.db = usbe_pkg::hsk(
                    (s.dpid == usbe_pkg::EP_ONE ? s.ctl2[usbe_pkg::B_EP1STALL] :
                     s.ctl2[usbe_pkg::B_EP2STALL]) ?
                    usbe_pkg::PID_STALL : usbe_pkg::PID_NAK);
                end
              end else if (s.tok != usbe_pkg::PID_SETUP &&
                           s.ctl0[usbe_pkg::B_EP0_FORCED_STALL]) begin
                n.db = usbe_pkg::hsk(usbe_pkg::PID_STALL);
              end else if (s.tok != usbe_pkg::PID_SETUP &&
                           s.ctl2[usbe_pkg::B_AUTOOUT] && lnk.h.empty &&
                           s.idx == 4'h0) begin
                n.db = usbe_pkg::hsk(usbe_pkg::PID_ACK);
              end else if (s.tok != usbe_pkg::PID_SETUP &&
                           (!s.ctl0[usbe_pkg::B_RXEN] ||
                            s.evst[usbe_pkg::B_RX0DONE])) begin
                n.db = usbe_pkg::hsk(usbe_pkg::PID_NAK);
              end else begin
                n.db = usbe_pkg::hsk(usbe_pkg::PID_ACK);
                if (s.tok == usbe_pkg::PID_SETUP ||
                    n.rtog == s.rxst[usbe_pkg::B_RXTOG]) begin
                  n.evst[usbe_pkg::B_RX0DONE] = 1'b1;
                  n.rxst[3:0] = n.idx;
                  n.rp = '0;
                end
              end
            end
          end
        end
        ST_TX: begin
          n.db.v = 1'b1;
          n.db.pid = s.dpid;
          n.db.ep = usbe_pkg::EP_ZERO;
          n.db.empty = s.cnt == 4'h0;
          n.db.last = s.cnt == 4'h0 || s.idx == s.cnt - 4'h1;
          n.db.b = s.shared ? s.buf1[s.idx[AW-1:0]] : s.buf0[s.idx[AW-1:0]];
          n.idx = s.idx + 4'h1;
          if (n.db.last) begin
            n.st = ST_WACK;
          end
        end
        ST_WACK: begin
          if (lnk.h.v) begin
            n.st = ST_IDLE;
            if (lnk.h.pid == usbe_pkg::PID_ACK) begin
              if (s.shared) begin
                n.evst[usbe_pkg::B_TX1DONE] = 1'b1;
              end else begin
                n.evst[usbe_pkg::B_TX0DONE] = 1'b1;
              end
            end
          end
        end
        default: n.st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.st <= ST_IDLE;
    end else begin
      s <= n;
    end
  end

  assign sfr_rdata = s.rdata;
  assign lnk.d = s.db;
  assign lnk.h_ready = tick;
  assign lnk.k_state = s.ctl1[usbe_pkg::B_WAKE];
endmodule

//--- rtl/usbe_pkg.sv
package usbe_pkg;
  // ---------------------------------------------------------------
  // Device register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_PRESC = 8'hE1;
  localparam logic [7:0] ADR_TX1DATA = 8'hE6;
  localparam logic [7:0] ADR_TX0DATA = 8'hE7;
  localparam logic [7:0] ADR_EVSTAT = 8'hE8;
  localparam logic [7:0] ADR_EVEN = 8'hE9;
  localparam logic [7:0] ADR_TX0CTL = 8'hEA;
  localparam logic [7:0] ADR_TX1CTL = 8'hEB;
  localparam logic [7:0] ADR_EPCTL = 8'hEC;
  localparam logic [7:0] ADR_RXSTAT = 8'hED;
  localparam logic [7:0] ADR_FADDR = 8'hEE;
  localparam logic [7:0] ADR_RXDATA = 8'hEF;
  localparam logic [7:0] RST_VAL = 8'h00;
  localparam logic [7:0] EPCTL_MASK = 8'h1F;
  // ---------------------------------------------------------------
  // Bit positions
  // ---------------------------------------------------------------
  localparam int B_TOGGLE = 7;
  localparam int B_SELECT = 6;
  localparam int B_EP0_FORCED_STALL = 6;
  localparam int B_TXEN = 5;
  localparam int B_WAKE = 4;
  localparam int B_RXEN = 4;
  localparam int B_AUTOOUT = 4;
  localparam int B_EP2EN = 3;
  localparam int B_EP1EN = 2;
  localparam int B_EP2STALL = 1;
  localparam int B_EP1STALL = 0;
  localparam int B_RXTOG = 7;
  localparam int B_SETUP = 6;
  localparam int B_IN = 5;
  localparam int B_OUT = 4;
  localparam int B_SUSP = 7;
  localparam int B_TX0DONE = 4;
  localparam int B_RX0DONE = 3;
  localparam int B_TX1DONE = 2;
  localparam int B_RESUME = 0;
  // ---------------------------------------------------------------
  // Packet identifiers
  // ---------------------------------------------------------------
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_SETUP = 4'hD;
  localparam logic [3:0] PID_DATA0 = 4'h3;
  localparam logic [3:0] PID_DATA1 = 4'hB;
  localparam logic [3:0] PID_ACK = 4'h2;
  localparam logic [3:0] PID_NAK = 4'hA;
  localparam logic [3:0] PID_STALL = 4'hE;
  localparam logic [3:0] EP_ZERO = 4'h0;
  localparam logic [3:0] EP_ONE = 4'h1;
  localparam logic [3:0] EP_TWO = 4'h2;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int USB_HZ = 6_000_000;
  localparam int SUSP_US = 3000;
  localparam int SUSP_TICKS = SUSP_US * (USB_HZ / 1_000_000);
  localparam int ANS_WAIT = 4000;
  // ---------------------------------------------------------------
  // Host controller registers
  // ---------------------------------------------------------------
  localparam logic [7:0] H_CMD = 8'h00;
  localparam logic [7:0] H_TXD = 8'h04;
  localparam logic [7:0] H_STAT = 8'h08;
  localparam logic [7:0] H_RXD = 8'h0C;
  localparam int C_EP_LSB = 4;
  localparam int C_CNT_LSB = 8;
  localparam int C_TOG = 12;

  typedef struct packed {
    logic v;
    logic last;
    logic empty;
    logic [3:0] pid;
    logic [3:0] ep;
    logic [7:0] b;
  } usbe_beat_t;

  function automatic logic [3:0] cnt_of(input logic [7:0] r);
    cnt_of = r[3:0];
  endfunction

  function automatic usbe_beat_t hsk(input logic [3:0] pid);
    hsk = '{v: 1'b1, last: 1'b1, empty: 1'b1, pid: pid,
            ep: EP_ZERO, b: RST_VAL};
  endfunction
endpackage

//--- rtl/usbe_link_if.sv
`timescale 1ns/1ps
interface usbe_link_if;
  usbe_pkg::usbe_beat_t h;
  usbe_pkg::usbe_beat_t d;
  logic h_ready;
  logic k_state;
  modport dev(input h, output d, output h_ready, output k_state);
  modport hst(output h, input d, input h_ready, input k_state);
endinterface

//--- rtl/usbe_tick_div.sv
`timescale 1ns/1ps
module usbe_tick_div #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [W-1:0] presc,
  output logic tick
);
  typedef struct packed {
    logic [W:0] cnt;
    logic tick;
  } usbe_div_t;
  usbe_div_t s, n;

  // Period is 2 * (presc + 1) core cycles
  always_comb begin
    n = s;
    n.tick = 1'b0;
    if (s.cnt >= {presc, 1'b1}) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = s.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick = s.tick;
endmodule

//--- rtl/usbe_host.sv
`timescale 1ns/1ps
module usbe_host #(
  parameter int BUF_DEPTH = 8,
  parameter int ANS_WAIT = usbe_pkg::ANS_WAIT
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  usbe_link_if.hst lnk
);
  localparam int AW = $clog2(BUF_DEPTH);

  generate
    if (BUF_DEPTH < 2 || BUF_DEPTH > 16 || (1 << AW) != BUF_DEPTH ||
        ANS_WAIT < 2 || ANS_WAIT > 65535) begin : g_bad
      $error("usbe_host: unsupported parameters");
    end
  endgenerate

  typedef enum logic [2:0] {H_IDLE, H_TOK, H_DATA, H_WAIT, H_ACK} usbe_hst_t;

  typedef struct packed {
    usbe_hst_t st;
    logic [3:0] pid;
    logic [3:0] ep;
    logic [3:0] cnt;
    logic tog;
    logic [3:0] idx;
    logic [BUF_DEPTH-1:0][7:0] tbuf;
    logic [BUF_DEPTH-1:0][7:0] rbuf;
    logic [AW-1:0] twp;
    logic [AW-1:0] rrp;
    logic [3:0] rcnt;
    logic [3:0] ans;
    logic [15:0] tmo;
    logic rdack;
    logic [31:0] rdata;
    usbe_pkg::usbe_beat_t hb;
  } usbe_host_t;

  usbe_host_t s, n;
  logic take;

  assign take = s.hb.v && lnk.h_ready;

  always_comb begin
    n = s;
    n.rdack = 1'b0;
    // -------------------------------------------------------------
    // Register access
    // -------------------------------------------------------------
    if (avs_read && !s.rdack) begin
      n.rdack = 1'b1;
      case (avs_address)
        usbe_pkg::H_STAT: n.rdata = {21'h000000, lnk.k_state, s.rcnt,
                                     s.ans, 1'b0, s.st != H_IDLE};
        usbe_pkg::H_RXD: begin
          n.rdata = {24'h000000, s.rbuf[s.rrp]};
          n.rrp = s.rrp + 1'b1;
        end
        default: n.rdata = 32'h00000000;
      endcase
    end
    if (avs_write && avs_address == usbe_pkg::H_TXD) begin
      n.tbuf[s.twp] = avs_writedata[7:0];
      n.twp = s.twp + 1'b1;
    end
    // -------------------------------------------------------------
    // Transaction sequencer
    // -------------------------------------------------------------
    case (s.st)
      H_IDLE: begin
        if (avs_write && avs_address == usbe_pkg::H_CMD) begin
          n.pid = avs_writedata[3:0];
          n.ep = avs_writedata[usbe_pkg::C_EP_LSB +: 4];
          n.cnt = avs_writedata[usbe_pkg::C_CNT_LSB +: 4];
          n.tog = avs_writedata[usbe_pkg::C_TOG];
          n.rcnt = '0;
          n.rrp = '0;
          n.ans = '0;
          n.hb = usbe_pkg::hsk(avs_writedata[3:0]);
          n.hb.ep = avs_writedata[usbe_pkg::C_EP_LSB +: 4];
          n.st = H_TOK;
        end
      end
      H_TOK, H_DATA: begin
        if (take) begin
          n.idx = s.st == H_TOK ? 4'h0 : s.idx + 4'h1;
          if (s.hb.last && (s.st == H_DATA || s.pid == usbe_pkg::PID_IN)) begin
            n.hb = '0;
            n.tmo = '0;
            n.st = H_WAIT;
          end else if (s.pid == usbe_pkg::PID_IN) begin
            n.hb = '0;
            n.tmo = '0;
            n.st = H_WAIT;
          end else begin
            n.st = H_DATA;
            n.hb.pid = s.tog ? usbe_pkg::PID_DATA1 : usbe_pkg::PID_DATA0;
            n.hb.empty = s.cnt == 4'h0;
            n.hb.last = s.cnt == 4'h0 || n.idx == s.cnt - 4'h1;
            n.hb.b = s.tbuf[n.idx[AW-1:0]];
          end
        end
      end
      H_WAIT: begin
        n.tmo = s.tmo + 16'h0001;
        if (lnk.d.v) begin
          if (!lnk.d.empty) begin
            n.rbuf[s.rcnt[AW-1:0]] = lnk.d.b;
            n.rcnt = s.rcnt + 4'h1;
          end
          if (lnk.d.last) begin
            n.ans = lnk.d.pid;
            n.st = H_IDLE;
            n.twp = '0;
            if (lnk.d.pid == usbe_pkg::PID_DATA0 ||
                lnk.d.pid == usbe_pkg::PID_DATA1) begin
              n.hb = usbe_pkg::hsk(usbe_pkg::PID_ACK);
              n.st = H_ACK;
            end
          end
        end else if (s.tmo == 16'(ANS_WAIT - 1)) begin
          n.st = H_IDLE;
          n.twp = '0;
        end
      end
      H_ACK: begin
        if (take) begin
          n.hb = '0;
          n.st = H_IDLE;
        end
      end
      default: n.st = H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.st <= H_IDLE;
    end else begin
      s <= n;
    end
  end

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = avs_read && !s.rdack;
  assign lnk.h = s.hb;
endmodule

//--- tb/usbe_link_properties.sv
`timescale 1ns/1ps
module usbe_link_properties (
  input logic core_clk,
  input logic nrst,
  input usbe_pkg::usbe_beat_t h,
  input usbe_pkg::usbe_beat_t d,
  input logic h_ready,
  input logic k_state
);
  // ------------------------------------------
  // Link timing and framing
  // ------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic hsk_d;
  logic take_h;
  assign take_h = h.v && h_ready;
  assign hsk_d = d.v && (d.pid == usbe_pkg::PID_ACK ||
    d.pid == usbe_pkg::PID_NAK || d.pid == usbe_pkg::PID_STALL);
  tick_pulse_a: assert property (h_ready |=> !h_ready)
    else $error("tick wider than one cycle");
  beat_pulse_a: assert property (d.v |=> !d.v)
    else $error("device beat held two cycles");
  beat_on_tick_a: assert property (d.v |-> $past(h_ready))
    else $error("device beat not after a tick");
  pid_legal_a: assert property (d.v |-> hsk_d ||
    d.pid == usbe_pkg::PID_DATA0 || d.pid == usbe_pkg::PID_DATA1)
    else $error("illegal device pid");
  hsk_form_a: assert property (hsk_d |-> d.last && d.empty)
    else $error("handshake not a single empty beat");
  data_run_a: assert property (d.v && !d.last &&
    d.pid == usbe_pkg::PID_DATA1 |-> ##[1:12]
    (d.v && d.pid == usbe_pkg::PID_DATA1))
    else $error("data packet pid changed or stalled");
  out_quiet_a: assert property (take_h &&
    h.pid == usbe_pkg::PID_OUT |=> !d.v)
    else $error("answer to bare OUT token");
  data_ack_a: assert property (take_h && h.last && !h.empty &&
    h.pid == usbe_pkg::PID_DATA0 |=> hsk_d)
    else $error("no handshake after received data");
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic core_clk;
  logic nrst;
  logic sfr_wr, sfr_rd, avs_read, avs_write, avs_waitrequest;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, avs_address;
  logic [31:0] avs_writedata, avs_readdata, s;
  int mismatches = 0;
  int checks_done = 0;
  usbe_link_if lnk();
  usbe_device i_usbe_device (.core_clk(core_clk), .nrst(nrst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .lnk(lnk.dev));
  usbe_host #(.ANS_WAIT(200)) i_usbe_host (.core_clk(core_clk),
    .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .lnk(lnk.hst));
  usbe_link_properties u_props (.core_clk(core_clk), .nrst(nrst),
    .h(lnk.h), .d(lnk.d), .h_ready(lnk.h_ready), .k_state(lnk.k_state));
  always #12.5 core_clk = ~core_clk;
  // ------------------------------------------
  // Bus tasks
  // ------------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task sw(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_wdata <= v;
    sfr_wr <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask
  task sc(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    @(negedge core_clk);
    chk(sfr_rdata, e);
  endtask
  task aw(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest);
    avs_write <= 1'b0;
  endtask
  task ar(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest);
    v = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task xfer(input logic [31:0] cmd);
    aw(8'h00, cmd);
    do ar(8'h08, s); while (s[0] !== 1'b0);
  endtask
  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  task t_regs;
    sc(8'hEB, 8'h00);
    sw(8'hE1, 8'h00);
    sc(8'hE1, 8'h00);
    sw(8'hEC, 8'hFF);
    sc(8'hEC, 8'h1F);
    sw(8'hEC, 8'h00);
    sc(8'hEC, 8'h00);
    sc(8'hD0, 8'h00);
    $display("t_regs done");
  endtask
  task t_in;
    sw(8'hEC, 8'h04);
    sw(8'hEB, 8'h00);
    sw(8'hE6, 8'h5A);
    sw(8'hE6, 8'hC3);
    sw(8'hEB, 8'hA2);
    xfer(32'h019);
    chk(s[9:2], 8'h2B);
    ar(8'h0C, s);
    chk(s[7:0], 8'h5A);
    ar(8'h0C, s);
    chk(s[7:0], 8'hC3);
    sc(8'hE8, 8'h04);
    xfer(32'h019);
    chk(8'(s[5:2]), 8'h0A);
    sw(8'hE8, 8'h00);
    sw(8'hEB, 8'h00);
    xfer(32'h019);
    chk(8'(s[5:2]), 8'h0A);
    $display("t_in done");
  endtask
  task t_sel;
    sw(8'hEC, 8'h08);
    sw(8'hEB, 8'h21);
    xfer(32'h029);
    chk(8'(s[5:2]), 8'h0A);
    sw(8'hEC, 8'h0A);
    xfer(32'h029);
    chk(8'(s[5:2]), 8'h0E);
    sw(8'hEC, 8'h00);
    sw(8'hEB, 8'h00);
    $display("t_sel done");
  endtask
  task t_ep0;
    sw(8'hEA, 8'h10);
    aw(8'h04, 32'h11);
    aw(8'h04, 32'h22);
    xfer(32'h201);
    chk(8'(s[5:2]), 8'h02);
    sc(8'hED, 8'h12);
    sc(8'hEF, 8'h11);
    sc(8'hEF, 8'h22);
    aw(8'h04, 32'h33);
    xfer(32'h10D);
    sc(8'hED, 8'h41);
    sw(8'hEC, 8'h10);
    xfer(32'h001);
    chk(8'(s[5:2]), 8'h02);
    $display("t_ep0 done");
  endtask
  task t_wake;
    sw(8'hE8, 8'h00);
    sw(8'hEB, 8'h10);
    repeat (4) @(posedge core_clk);
    chk(8'(lnk.k_state), 8'h01);
    sc(8'hE8, 8'h00);
    sw(8'hEB, 8'h00);
    @(negedge core_clk);
    chk(8'(lnk.k_state), 8'h00);
    $display("t_wake done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    {sfr_wr, sfr_rd, avs_read, avs_write} = 4'h0;
    {sfr_addr, sfr_wdata, avs_address} = 24'h000000;
    avs_writedata = 32'h00000000;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    t_regs;
    t_in;
    t_sel;
    t_ep0;
    t_wake;
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    tally_and_finish;
  end
endmodule
